// ===== design/hdlc_pkg.sv
// What this block does
// - one instance on the system clock, engine-core data
// - transmit order: checksum, stuffing, flags, idle
// - transmit checksum selectable 16 or 32 bit
// - stuff a zero after five ones
// - flag byte opens and closes every frame
// - start flags zero to two, zero shares
// - 32-bit checksum, short frames: one flag max
// - every flag sent whole, no bit sharing
// - idle as repeated flags or all ones
// - optional bit reversal per byte, both ways
// - abort sets abort and frame end flags
// - bits outside frames dropped silently
// - receiver accepts either idle form
// - flags mark frames, shared zero accepted
// - receiver deletes zero after five ones
// - receiver checks checksum, flags error
// - checksum error only without abort or residue
// - non-whole byte frame is residual error
// - one to three byte frames dropped silently unless aborted
// - 32-bit, four-five bytes: alignment error
// - longer frames passed on and reported
package hdlc_pkg;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TXLEN = 8'h04;
   localparam logic [7:0] OFS_TXDATA = 8'h08;
   localparam logic [7:0] OFS_RXDATA = 8'h0c;
   localparam logic [7:0] OFS_RECEIVE_STATUS_WORD = 8'h10;
   localparam logic [7:0] OFS_RXTAIL = 8'h14;
   localparam logic [31:0] POLY16 = 32'h00008408;
   localparam logic [31:0] POLY32 = 32'hedb88320;
   localparam logic [31:0] INIT16 = 32'h0000ffff;
   localparam logic [31:0] INIT32 = 32'hffffffff;
   localparam logic [31:0] GOOD16 = 32'h0000f0b8;
   localparam logic [31:0] GOOD32 = 32'hdebb20e3;
   localparam logic [7:0] FLAG_BYTE = 8'h7e;
   localparam logic [7:0] IDLE_ONES = 8'hff;
   localparam logic [15:0] SHORT_MAX = 16'h0003;
   localparam logic [15:0] ALIGN_MAX = 16'h0005;
   localparam logic [15:0] CLAMP_LEN = 16'h0004;
   localparam logic [2:0] BIT_END = 3'h6;
   typedef enum logic [2:0] {
      T_IDLE = 3'b000, T_SFLAG = 3'b001, T_DATA = 3'b010, T_FCS = 3'b011, T_EFLAG = 3'b100
   } tx_st_t;
   // control word, bit 0 upward: crc32, idle_ones, start flags, tx/rx reversal
   typedef struct packed {
      logic rx_rev;
      logic tx_rev;
      logic [1:0] nflag;
      logic idle_ones;
      logic crc32;
   } ctrl_t;
   localparam ctrl_t CTRL_RST = 6'h00;
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } hold_t;
   typedef struct packed {
      tx_st_t st;
      logic [31:0] sh;
      logic [5:0] nbit;
      logic [2:0] ones;
      logic raw;
      logic [31:0] crc;
      logic [1:0] nflag;
      logic last;
      logic flag_tail;
      logic bit_out;
   } tx_t;
   typedef struct packed {
      logic in_frame;
      logic [2:0] ones;
      logic [2:0] bitcnt;
      logic [7:0] sh;
      logic [31:0] crc;
      logic [15:0] len;
      logic [23:0] line;
      logic [1:0] lcnt;
   } rx_t;
   typedef struct packed {
      logic valid;
      logic ovr;
      logic [7:0] data;
   } rxd_t;
   // receive_status_word, read as {len, 10 zero bits, these six}
   typedef struct packed {
      logic [15:0] len;
      logic align;
      logic residual;
      logic checksum_error_flag;
      logic abort_seen_flag;
      logic frame_end_flag;
      logic valid;
   } stat_t;
   typedef struct packed {
      ctrl_t ctrl;
      logic [15:0] txlen;
      hold_t hold;
      tx_t tx;
      rx_t rx;
      rxd_t rxd;
      stat_t stat;
      logic [23:0] tail;
      logic underrun;
      logic ack;
      logic [31:0] dat;
   } state_t;
endpackage

// ===== design/hdlc_framer.sv
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module hdlc_framer
   import hdlc_pkg::*;
#(
   parameter int ADR_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic tx_bit_en_i,
   output logic tx_bit_o,
   input wire logic rx_bit_en_i,
   input wire logic rx_bit_i
);

   state_t s_ff;
   state_t nxt_s;
   logic req;
   logic [7:0] adr;
   logic [31:0] wmask;
   logic [31:0] wd;
   logic [1:0] nf;
   logic d;
   logic done_byte;
   logic [7:0] inb;
   logic residual;

   ////////////////////////////////////////////////////////////////////////////
   // one reflected crc step; the 16-bit poly keeps the upper half at zero
   function automatic logic [31:0] crc_bit(input logic [31:0] c, input logic b, input logic w32);
      logic [31:0] r;
      r = {1'b0, c[31:1]};
      if (c[0] ^ b)
      begin
         r = r ^ (w32 ? POLY32 : POLY16);
      end
      return r;
   endfunction

   function automatic logic [7:0] rev8(input logic [7:0] b);
      logic [7:0] r;
      for (int i = 0; i < 8; i++)
      begin
         r[i] = b[7-i];
      end
      return r;
   endfunction

   // load the next unit into the serialiser; only flags and idle are raw
   function automatic tx_t ld(input tx_t t, input logic [31:0] v, input logic [5:0] nb,
                              input logic raw);
      tx_t r;
      r = t;
      r.sh = v;
      r.nbit = nb;
      r.raw = raw;
      r.flag_tail = raw && (v[7:0] == FLAG_BYTE);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign req = wb_cyc_i && wb_stb_i && !s_ff.ack;
   assign adr = 8'(wb_adr_i);
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wd = wb_dat_i & wmask;
   assign wb_dat_o = s_ff.dat;
   assign wb_ack_o = s_ff.ack;
   assign tx_bit_o = s_ff.tx.bit_out;

   // all next-state logic; bus clears run first so hardware sets win
   always_comb
   begin
      nxt_s = s_ff;
      nf = 2'h0;
      d = rx_bit_i;
      done_byte = 1'b0;
      inb = {d, s_ff.rx.sh[7:1]};
      residual = 1'b0;
      nxt_s.ack = 1'b0;
      // wishbone slave: a tx byte write waits for the holding register
      if (req && !(wb_we_i && adr == OFS_TXDATA && s_ff.hold.valid))
      begin
         nxt_s.ack = 1'b1;
         nxt_s.dat = 32'h0;
         if (wb_we_i)
         begin
            if (adr == OFS_CTRL)
            begin
               nxt_s.ctrl = ctrl_t'(6'((32'(s_ff.ctrl) & ~wmask) | wd));
            end
            else if (adr == OFS_TXLEN)
            begin
               nxt_s.txlen = 16'(({16'h0, s_ff.txlen} & ~wmask) | wd);
            end
            else if (adr == OFS_TXDATA)
            begin
               nxt_s.hold = {1'b1, wb_dat_i[8], wb_dat_i[7:0]};
            end
         end
         else if (adr == OFS_CTRL)
         begin
            nxt_s.dat = {26'h0, s_ff.ctrl};
         end
         else if (adr == OFS_TXLEN)
         begin
            nxt_s.dat = {16'h0, s_ff.txlen};
         end
         else if (adr == OFS_TXDATA)
         begin
            nxt_s.dat = {29'h0, s_ff.underrun, s_ff.tx.st != T_IDLE, s_ff.hold.valid};
            nxt_s.underrun = 1'b0;
         end
         else if (adr == OFS_RXDATA)
         begin
            nxt_s.dat = {22'h0, s_ff.rxd.ovr, s_ff.rxd.valid, s_ff.rxd.data};
            nxt_s.rxd = '0;
         end
         else if (adr == OFS_RECEIVE_STATUS_WORD)
         begin
            nxt_s.dat = {s_ff.stat.len, 10'h0, s_ff.stat[5:0]};
            nxt_s.stat = '0;
         end
         else if (adr == OFS_RXTAIL)
         begin
            nxt_s.dat = {8'h0, s_ff.tail};
         end
      end

      //////////////////////////////////////////////////////////////////////////
      // transmit serialiser, one line bit per tx_bit_en_i
      if (tx_bit_en_i)
      begin
         if (s_ff.tx.ones == 3'd5)
         begin
            nxt_s.tx.bit_out = 1'b0;
            nxt_s.tx.ones = 3'd0;
         end
         else
         begin
            if (s_ff.tx.nbit == 6'd0)
            begin
               unique case (s_ff.tx.st)
                  T_IDLE, T_EFLAG:
                  begin
                     if (s_ff.hold.valid)
                     begin
                        nf = (s_ff.ctrl.nflag == 2'd3) ? 2'd2 : s_ff.ctrl.nflag;
                        if (s_ff.ctrl.crc32 && s_ff.txlen <= CLAMP_LEN && nf == 2'd2)
                        begin
                           nf = 2'd1;
                        end
                        // sharing only works when the last thing sent was a flag
                        if (nf == 2'd0 && !s_ff.tx.flag_tail)
                        begin
                           nf = 2'd1;
                        end
                        nxt_s.tx.crc = s_ff.ctrl.crc32 ? INIT32 : INIT16;
                        if (nf != 2'd0)
                        begin
                           nxt_s.tx = ld(nxt_s.tx, {24'h0, FLAG_BYTE}, 6'd8, 1'b1);
                           nxt_s.tx.st = T_SFLAG;
                           nxt_s.tx.nflag = nf - 2'd1;
                        end
                        else
                        begin
                           nxt_s.tx = ld(nxt_s.tx, {24'h0, s_ff.ctrl.tx_rev ?
                                         rev8(s_ff.hold.data) : s_ff.hold.data}, 6'd8, 1'b0);
                           nxt_s.tx.st = T_DATA;
                           nxt_s.tx.last = s_ff.hold.last;
                           nxt_s.hold.valid = 1'b0;
                        end
                     end
                     else
                     begin
                        nxt_s.tx = ld(nxt_s.tx, {24'h0, s_ff.ctrl.idle_ones ? IDLE_ONES :
                                      FLAG_BYTE}, 6'd8, 1'b1);
                        nxt_s.tx.st = T_IDLE;
                     end
                  end
                  T_SFLAG:
                  begin
                     if (s_ff.tx.nflag != 2'd0 || !s_ff.hold.valid)
                     begin
                        nxt_s.tx = ld(nxt_s.tx, {24'h0, FLAG_BYTE}, 6'd8, 1'b1);
                        nxt_s.tx.nflag = (s_ff.tx.nflag != 2'd0) ? s_ff.tx.nflag - 2'd1 : 2'd0;
                     end
                     else
                     begin
                        nxt_s.tx = ld(nxt_s.tx, {24'h0, s_ff.ctrl.tx_rev ?
                                      rev8(s_ff.hold.data) : s_ff.hold.data}, 6'd8, 1'b0);
                        nxt_s.tx.st = T_DATA;
                        nxt_s.tx.last = s_ff.hold.last;
                        nxt_s.hold.valid = 1'b0;
                     end
                  end
                  T_DATA:
                  begin
                     if (!s_ff.tx.last && s_ff.hold.valid)
                     begin
                        nxt_s.tx = ld(nxt_s.tx, {24'h0, s_ff.ctrl.tx_rev ?
                                      rev8(s_ff.hold.data) : s_ff.hold.data}, 6'd8, 1'b0);
                        nxt_s.tx.last = s_ff.hold.last;
                        nxt_s.hold.valid = 1'b0;
                     end
                     else
                     begin
                        // a starved frame is closed cleanly and flagged for software
                        // built on the cleared copy so a status read cannot resurrect it
                        nxt_s.underrun = nxt_s.underrun | !s_ff.tx.last;
                        nxt_s.tx = ld(nxt_s.tx, ~s_ff.tx.crc & (s_ff.ctrl.crc32 ? INIT32 :
                                      INIT16), s_ff.ctrl.crc32 ? 6'd32 : 6'd16, 1'b0);
                        nxt_s.tx.st = T_FCS;
                     end
                  end
                  T_FCS:
                  begin
                     nxt_s.tx = ld(nxt_s.tx, {24'h0, FLAG_BYTE}, 6'd8, 1'b1);
                     nxt_s.tx.st = T_EFLAG;
                  end
                  default:
                  begin
                     nxt_s.tx = ld(nxt_s.tx, {24'h0, FLAG_BYTE}, 6'd8, 1'b1);
                     nxt_s.tx.st = T_IDLE;
                  end
               endcase
            end
            nxt_s.tx.bit_out = nxt_s.tx.sh[0];
            nxt_s.tx.sh = {1'b0, nxt_s.tx.sh[31:1]};
            nxt_s.tx.nbit = nxt_s.tx.nbit - 6'd1;
            if (nxt_s.tx.raw)
            begin
               nxt_s.tx.ones = 3'd0;
            end
            else
            begin
               if (nxt_s.tx.st == T_DATA)
               begin
                  nxt_s.tx.crc = crc_bit(nxt_s.tx.crc, nxt_s.tx.bit_out, s_ff.ctrl.crc32);
               end
               nxt_s.tx.ones = nxt_s.tx.bit_out ? s_ff.tx.ones + 3'd1 : 3'd0;
            end
         end
      end

      //////////////////////////////////////////////////////////////////////////
      // receive deframer, one line bit per rx_bit_en_i
      if (rx_bit_en_i)
      begin
         if (d)
         begin
            nxt_s.rx.ones = (s_ff.rx.ones == 3'd7) ? 3'd7 : s_ff.rx.ones + 3'd1;
            if (s_ff.rx.ones == 3'd6 && s_ff.rx.in_frame)
            begin
               nxt_s.rx.in_frame = 1'b0;
               if (s_ff.rx.len != 16'h0)
               begin
                  nxt_s.stat = {s_ff.rx.len, 6'b000111};
                  nxt_s.tail = s_ff.rx.line;
               end
            end
            // sixth and seventh ones are held back as flag or abort candidates
            done_byte = s_ff.rx.in_frame && s_ff.rx.ones < 3'd5;
         end
         else
         begin
            nxt_s.rx.ones = 3'd0;
            if (s_ff.rx.ones == 3'd6)
            begin
               if (s_ff.rx.in_frame && s_ff.rx.len > SHORT_MAX)
               begin
                  residual = s_ff.rx.bitcnt != BIT_END;
                  nxt_s.stat.valid = 1'b1;
                  nxt_s.stat.frame_end_flag = 1'b1;
                  nxt_s.stat.abort_seen_flag = 1'b0;
                  nxt_s.stat.residual = residual;
                  nxt_s.stat.len = s_ff.rx.len;
                  nxt_s.stat.align = s_ff.ctrl.crc32 && s_ff.rx.len <= ALIGN_MAX;
                  nxt_s.stat.checksum_error_flag = !residual && (s_ff.rx.crc !=
                                                   (s_ff.ctrl.crc32 ? GOOD32 : GOOD16));
                  nxt_s.tail = s_ff.rx.line;
               end
               nxt_s.rx.in_frame = 1'b1;
               nxt_s.rx.bitcnt = 3'd0;
               nxt_s.rx.len = 16'h0;
               nxt_s.rx.lcnt = 2'd0;
               nxt_s.rx.crc = s_ff.ctrl.crc32 ? INIT32 : INIT16;
            end
            else
            begin
               done_byte = s_ff.rx.in_frame && s_ff.rx.ones != 3'd5;
            end
         end
         // outside a frame nothing is shifted
         if (done_byte)
         begin
            nxt_s.rx.sh = inb;
            nxt_s.rx.bitcnt = s_ff.rx.bitcnt + 3'd1;
            if (s_ff.rx.bitcnt == 3'd7)
            begin
               for (int i = 0; i < 8; i++)
               begin
                  nxt_s.rx.crc = crc_bit(nxt_s.rx.crc, inb[i], s_ff.ctrl.crc32);
               end
               nxt_s.rx.len = (s_ff.rx.len == 16'hffff) ? s_ff.rx.len : s_ff.rx.len + 16'h1;
               nxt_s.rx.line = {s_ff.ctrl.rx_rev ? rev8(inb) : inb, s_ff.rx.line[23:8]};
               // three bytes are withheld so short frames never reach software
               if (s_ff.rx.lcnt == 2'd3)
               begin
                  nxt_s.rxd.ovr = nxt_s.rxd.valid;
                  nxt_s.rxd.valid = 1'b1;
                  nxt_s.rxd.data = s_ff.rx.line[7:0];
               end
               else
               begin
                  nxt_s.rx.lcnt = s_ff.rx.lcnt + 2'd1;
               end
            end
         end
      end
   end

   // single state register
   // one system clock
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_ff <= '0;
         s_ff.ctrl <= CTRL_RST;
         s_ff.tx.st <= T_IDLE;
         s_ff.tx.bit_out <= 1'b1;
      end
      else
      begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_enter_fcs;
      s_ff.tx.st != T_FCS ##1 s_ff.tx.st == T_FCS;
   endsequence
   sequence s_leave_fcs;
      s_ff.tx.st == T_FCS ##1 s_ff.tx.st != T_FCS;
   endsequence

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_tx_stuff: assert property (
      tx_bit_en_i && s_ff.tx.ones == 3'd5 |=> !tx_bit_o && s_ff.tx.ones == 3'd0)
      else $error("no zero after five ones");
   a_fcs_after_data: assert property (
      s_enter_fcs |-> $past(s_ff.tx.st) == T_DATA)
      else $error("checksum not preceded by data");
   a_flag_whole: assert property (
      s_leave_fcs |-> s_ff.tx.st == T_EFLAG && s_ff.tx.raw && s_ff.tx.nbit == 6'd7)
      else $error("closing flag not a full byte");
   a_flag_pattern: assert property (
      $rose(s_ff.tx.st == T_EFLAG) |-> !tx_bit_o && s_ff.tx.sh[6:0] == 7'h3f)
      else $error("closing flag pattern wrong");
   a_start_clamp: assert property (
      $rose(s_ff.tx.st == T_SFLAG) && s_ff.ctrl.crc32 && s_ff.txlen <= CLAMP_LEN
      |-> s_ff.tx.nflag == 2'd0)
      else $error("short crc32 frame sent two flags");
   a_abort_eof: assert property (
      $rose(s_ff.stat.abort_seen_flag) |-> s_ff.stat.frame_end_flag && s_ff.stat.valid)
      else $error("abort without frame end");
   a_fcs_masked: assert property (
      s_ff.stat.checksum_error_flag |-> !s_ff.stat.abort_seen_flag && !s_ff.stat.residual)
      else $error("checksum error shown beside another error");
   a_short_drop: assert property (
      $rose(s_ff.stat.valid) && !s_ff.stat.abort_seen_flag |-> s_ff.stat.len > SHORT_MAX)
      else $error("short frame reported");
   a_align_err: assert property (
      $rose(s_ff.stat.valid) && !s_ff.stat.abort_seen_flag
      |-> s_ff.stat.align == (s_ff.ctrl.crc32 && s_ff.stat.len <= ALIGN_MAX))
      else $error("alignment indication wrong");
   a_rx_destuff: assert property (
      rx_bit_en_i && !rx_bit_i && s_ff.rx.ones == 3'd5 && s_ff.rx.in_frame
      |=> s_ff.rx.bitcnt == $past(s_ff.rx.bitcnt) && s_ff.rx.len == $past(s_ff.rx.len))
      else $error("stuffed zero kept");

endmodule
`default_nettype wire

// ===== tb/line_partner.sv
`timescale 1ns/1ns
`default_nettype none
// line side: paces the bit clock and loops transmit back into receive
module line_partner
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stall_i,
   input wire logic inj_i,
   input wire logic inj_bit_i,
   input wire logic tx_bit_i,
   output logic tx_bit_en_o,
   output logic rx_bit_en_o,
   output logic rx_bit_o
);
   logic [1:0] div_ff;
   // one bit every fourth free cycle; a stall freezes the line clock
   always_ff @(posedge clk_i)
   begin
      div_ff <= rst_i ? 2'h0 : div_ff + {1'b0, !stall_i};
      rx_bit_en_o <= !rst_i && tx_bit_en_o;
   end
   assign tx_bit_en_o = !stall_i && div_ff == 2'h3;
   assign rx_bit_o = inj_i ? inj_bit_i : tx_bit_i; // bench bits bypass the loop
endmodule
`default_nettype wire

// ===== tb/tb_hdlc_bit_framing_coprocessor.sv
`timescale 1ns/1ns
`default_nettype none
module tb_hdlc_bit_framing_coprocessor
   import hdlc_pkg::*;
;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stall = 0, inj = 0, inj_bit = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, q, s, f;
   logic [5:0] ctrl;
   logic c32, rev;
   logic [7:0] pay [$];
   wire logic [31:0] rdat;
   wire logic ack, txb, txen, rxen, rxb;
   int failures = 0, samples_checked = 0, n;
   hdlc_framer u_hdlc_framer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .tx_bit_en_i(txen), .tx_bit_o(txb), .rx_bit_en_i(rxen), .rx_bit_i(rxb));
   line_partner u_line_partner (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .inj_i(inj),
      .inj_bit_i(inj_bit), .tx_bit_i(txb), .tx_bit_en_o(txen), .rx_bit_en_o(rxen),
      .rx_bit_o(rxb));
   always #10 clk_i = ~clk_i;
   // random stalls keep the far side slow at times
   always @(posedge clk_i) stall <= ($urandom % 4) == 0;
   ////////////////////////////////////////////////////////////////////////////////
   task finish_test;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // classic cycle: hold everything until ack is sampled, then release
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && k < 3000)
      begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 3000) failures++;
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   // reflected crc over the payload, inverted as it goes on the line
   function automatic logic [31:0] fcs();
      logic [31:0] r;
      r = c32 ? INIT32 : INIT16;
      foreach (pay[i])
      begin
         r ^= {24'h0, pay[i]};
         repeat (8) r = r[0] ? (r >> 1) ^ (c32 ? POLY32 : POLY16) : r >> 1;
      end
      return ~r;
   endfunction
   task send(input int len);
      pay.delete();
      for (int i = 0; i < len; i++) pay.push_back(8'($urandom));
      pay[0] = FLAG_BYTE; // flag pattern in content must be stuffed
      wb(1'b1, OFS_TXLEN, 32'(len), q);
      foreach (pay[i]) wb(1'b1, OFS_TXDATA, {23'h0, i == len - 1, pay[i]}, q);
   endtask
   task wait_end();
      int k;
      k = 0;
      s = 32'h0;
      while (s[1] !== 1'b1 && k < 400)
      begin
         wb(1'b0, OFS_RECEIVE_STATUS_WORD, 32'h0, s);
         k++;
      end
   endtask
   task line(input logic [7:0] v, input int nb);
      for (int i = 0; i < nb; i++)
      begin
         inj_bit <= v[i];
         @(posedge clk_i);
         while (rxen !== 1'b1) @(posedge clk_i);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (60000) @(posedge clk_i);
      failures++;
      finish_test();
   end
   initial
   begin
      void'($urandom(32'hc747fb0e));
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, OFS_CTRL, 32'h0, q);
      chk(q, 32'h0, "ctrl reset");
      wb(1'b0, 8'h3c, 32'h0, q);
      chk(q, 32'h0, "unmapped");
      // looped frames under random settings, both checksums
      for (int t = 0; t < 6; t++)
      begin
         c32 = t[0];
         rev = (t > 3);
         ctrl = {rev, rev, 2'($urandom), 1'($urandom), c32};
         wb(1'b1, OFS_CTRL, {26'h0, ctrl}, q);
         wb(1'b0, OFS_CTRL, 32'h0, q);
         chk(q, {26'h0, ctrl}, "ctrl");
         n = 4 + $urandom % 9;
         send(n);
         wait_end();
         f = fcs();
         chk(s & 32'h3f, 32'h3, "status");
         chk(s >> 16, 32'(n + (c32 ? 4 : 2)), "length");
         wb(1'b0, OFS_RXTAIL, 32'h0, q);
         if (!rev)
            chk(q, c32 ? {8'h0, f[31:8]} : {8'h0, f[15:0], pay[n-1]}, "tail");
      end
      c32 = 1'b1;
      wb(1'b1, OFS_CTRL, 32'h9, q);
      send(1);
      wait_end();
      chk(s & 32'h3e, 32'h22, "align");
      c32 = 1'b0;
      wb(1'b1, OFS_CTRL, 32'h0, q);
      send(1);
      // wait until the byte has left the holding register and the frame is closed
      q = 32'h3;
      for (int k = 0; k < 300 && q[1:0] !== 2'b00; k++) wb(1'b0, OFS_TXDATA, 32'h0, q);
      repeat (100) @(posedge clk_i);
      wb(1'b0, OFS_RECEIVE_STATUS_WORD, 32'h0, s);
      chk(s, 32'h0, "short drop");
      // hand-made line bits: abort, bad checksum, residual bits
      inj <= 1'b1;
      line(8'hff, 8);
      line(FLAG_BYTE, 8);
      line(8'h55, 8);
      line(8'h55, 8);
      line(8'hff, 8);
      wait_end();
      chk(s & 32'he, 32'h6, "abort");
      // drain old receive bytes so the next frame shows no overrun
      wb(1'b0, OFS_RXDATA, 32'h0, q);
      line(FLAG_BYTE, 8);
      for (int i = 1; i < 5; i++) line(8'(i), 8);
      line(FLAG_BYTE, 8);
      wait_end();
      chk(s & 32'h1a, 32'ha, "bad checksum");
      wb(1'b0, OFS_RXDATA, 32'h0, q);
      chk(q, 32'h101, "rx byte");
      for (int i = 0; i < 5; i++) line(8'h55, 8);
      line(8'h00, 3);
      line(FLAG_BYTE, 8);
      wait_end();
      chk(s & 32'h1a, 32'h12, "residual");
      finish_test();
   end
endmodule
`default_nettype wire
